// ==== verilog/rrad_decoder.sv ====
/*
 Remote register access command decoder. Parses the UDP payload byte stream,
 keeps a memory pointer and an info pointer per space, drives a simple memory request port and streams
 read data back as reply bytes. Assumes the receive engine, reply framer and
 memory spaces all run on i_clk; o_reply_end closes one reply datagram.
*/
`timescale 1ns/10ps
module rrad_decoder #(
    parameter logic [127:0] SIZE_DESC = {8{rrad_pkg::SIZE_DFLT}},
    parameter logic [127:0] RANGE_DESC = {8{rrad_pkg::RANGE_DFLT}},
    parameter logic [511:0] LABELS = 512'h0
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_last,
    input wire logic [15:0] i_rx_dst_port,
    input wire logic [15:0] i_rx_src_port,
    output logic o_rx_ready,
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    input wire logic i_tx_ready,
    output logic o_reply_end,
    output logic [15:0] o_reply_port,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [2:0] o_mem_space,
    output logic [1:0] o_mem_size,
    output logic [15:0] o_mem_addr,
    output logic [63:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [63:0] i_mem_rdata,
    output logic o_err_zero_count,
    input wire logic i_err_clear
);
    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    // Info areas always move in 16-bit elements whatever width is asked.
    function automatic logic [3:0] elem_bytes(input logic info, input logic [1:0] sz);
        elem_bytes = info ? rrad_pkg::INFO_BYTES : (rrad_pkg::ONE_BYTE << sz);
    endfunction

    rrad_pkg::rrad_state_t st_reg, st_next;
    logic [15:0] cmd_reg, cmd_next;
    logic [6:0] cnt_reg, cnt_next;
    logic [2:0] bidx_reg, bidx_next;
    logic [63:0] data_reg, data_next;
    logic [15:0] ptr_reg [0:7];
    logic [15:0] ptr_next [0:7];
    logic [15:0] iptr_reg [0:7];
    logic [15:0] iptr_next [0:7];
    logic err_reg, err_next;
    logic eop_reg, eop_next;
    logic ok_reg, ok_next;
    logic inpkt_reg, inpkt_next;
    logic [15:0] port_reg, port_next;
    logic end_reg, end_next;
    logic [15:0] cw;
    logic c_wr, c_adr, c_info, c_inc;
    logic [2:0] c_sp;
    logic [1:0] c_sz;
    logic [6:0] c_cnt;
    logic [3:0] nb;
    logic elem_end;
    logic take;
    logic port_ok;
    logic [15:0] new_addr;

    rrad_info_if info_bus ();

    rrad_info #(
        .SIZE_DESC(SIZE_DESC),
        .RANGE_DESC(RANGE_DESC),
        .LABELS(LABELS)
    ) u_info (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .bus(info_bus)
    );

    // -------------------------------------------------------------------
    // Command field decode
    // -------------------------------------------------------------------
    // While the high byte arrives the fields are taken from the bus directly.
    assign cw = (st_reg == rrad_pkg::ST_CMD_HI) ? {i_rx_data, cmd_reg[7:0]} : cmd_reg;
    assign c_wr = cw[rrad_pkg::CMD_WR];
    assign c_adr = cw[rrad_pkg::CMD_ADR];
    assign c_info = cw[rrad_pkg::CMD_INFO];
    assign c_sp = cw[rrad_pkg::CMD_SP_HI:rrad_pkg::CMD_SP_LO];
    assign c_sz = cw[rrad_pkg::CMD_SZ_HI:rrad_pkg::CMD_SZ_LO];
    assign c_inc = cw[rrad_pkg::CMD_INC];
    assign c_cnt = cw[rrad_pkg::CMD_CNT_HI:0];
    assign nb = elem_bytes(c_info, c_sz);
    assign elem_end = {1'b0, bidx_reg} == (nb - rrad_pkg::ONE_BYTE);
    assign new_addr = {i_rx_data, data_reg[7:0]};

    // -------------------------------------------------------------------
    // Handshakes and ports
    // -------------------------------------------------------------------
    // The parser holds off the next packet until the reply end has gone out.
    assign o_rx_ready = ((st_reg == rrad_pkg::ST_CMD_LO) && !eop_reg)
        || (st_reg == rrad_pkg::ST_CMD_HI) || (st_reg == rrad_pkg::ST_ADR_LO)
        || (st_reg == rrad_pkg::ST_ADR_HI) || (st_reg == rrad_pkg::ST_WDATA);
    assign take = i_rx_valid && o_rx_ready;
    assign port_ok = inpkt_reg ? ok_reg : (i_rx_dst_port == rrad_pkg::UDP_PORT);
    assign o_tx_valid = (st_reg == rrad_pkg::ST_RDOUT);
    assign o_tx_data = data_reg[7:0];
    assign o_reply_end = end_reg;
    assign o_reply_port = port_reg;
    assign o_mem_req = (st_reg == rrad_pkg::ST_ACCESS) && !c_info;
    assign o_mem_we = c_wr;
    assign o_mem_space = c_sp;
    assign o_mem_size = c_sz;
    assign o_mem_addr = ptr_reg[c_sp];
    assign o_mem_wdata = data_reg;
    assign o_err_zero_count = err_reg;
    assign info_bus.space = c_sp;
    assign info_bus.addr = iptr_reg[c_sp];
    assign info_bus.ptr = ptr_reg[c_sp];

    // -------------------------------------------------------------------
    // Parser next state
    // -------------------------------------------------------------------
    // A packet that ends inside a command abandons that command; partial
    // writes are never issued with half-assembled data.
    always_comb begin
        st_next = st_reg;
        cmd_next = cmd_reg;
        cnt_next = cnt_reg;
        bidx_next = bidx_reg;
        data_next = data_reg;
        ptr_next = ptr_reg;
        iptr_next = iptr_reg;
        err_next = err_reg && !i_err_clear;
        eop_next = eop_reg;
        ok_next = ok_reg;
        inpkt_next = inpkt_reg;
        port_next = port_reg;
        end_next = 1'b0;
        if (take) begin
            inpkt_next = !i_rx_last;
            if (!inpkt_reg) begin
                ok_next = i_rx_dst_port == rrad_pkg::UDP_PORT;
                port_next = i_rx_src_port;
            end
            if (i_rx_last && port_ok) begin
                eop_next = 1'b1;
            end
        end
        case (st_reg)
            rrad_pkg::ST_CMD_LO: begin
                if (eop_reg) begin
                    end_next = 1'b1;
                    eop_next = 1'b0;
                end else if (take && port_ok && !i_rx_last) begin
                    cmd_next[7:0] = i_rx_data;
                    st_next = rrad_pkg::ST_CMD_HI;
                end
            end
            rrad_pkg::ST_CMD_HI: begin
                if (take) begin
                    cmd_next[15:8] = i_rx_data;
                    cnt_next = c_cnt;
                    bidx_next = 3'h0;
                    if (c_cnt == rrad_pkg::CNT_ZERO) begin
                        err_next = 1'b1;
                    end
                    if (c_adr && !i_rx_last) begin
                        st_next = rrad_pkg::ST_ADR_LO;
                    end else if (c_adr || c_cnt == rrad_pkg::CNT_ZERO) begin
                        st_next = rrad_pkg::ST_CMD_LO;
                    end else if (c_wr) begin
                        st_next = i_rx_last ? rrad_pkg::ST_CMD_LO : rrad_pkg::ST_WDATA;
                    end else begin
                        st_next = rrad_pkg::ST_ACCESS;
                    end
                end
            end
            rrad_pkg::ST_ADR_LO: begin
                if (take) begin
                    data_next[7:0] = i_rx_data;
                    st_next = i_rx_last ? rrad_pkg::ST_CMD_LO : rrad_pkg::ST_ADR_HI;
                end
            end
            rrad_pkg::ST_ADR_HI: begin
                if (take) begin
                    // A zero-count command consumes its address but loads nothing.
                    if (c_cnt == rrad_pkg::CNT_ZERO) begin
                        st_next = rrad_pkg::ST_CMD_LO;
                    end else begin
                        if (c_info) begin
                            iptr_next[c_sp] = new_addr;
                        end else begin
                            ptr_next[c_sp] = new_addr;
                        end
                        if (!c_wr) begin
                            st_next = rrad_pkg::ST_ACCESS;
                        end else begin
                            st_next = i_rx_last ? rrad_pkg::ST_CMD_LO : rrad_pkg::ST_WDATA;
                        end
                    end
                end
            end
            rrad_pkg::ST_WDATA: begin
                if (take) begin
                    data_next[{bidx_reg, 3'h0} +: 8] = i_rx_data;
                    if (elem_end) begin
                        bidx_next = 3'h0;
                        st_next = rrad_pkg::ST_ACCESS;
                    end else if (i_rx_last) begin
                        st_next = rrad_pkg::ST_CMD_LO;
                    end else begin
                        bidx_next = bidx_reg + 3'h1;
                    end
                end
            end
            rrad_pkg::ST_ACCESS: begin
                bidx_next = 3'h0;
                // Writes to an info area are swallowed; it is read-only.
                if (c_info) begin
                    data_next = c_wr ? data_reg : {48'h0, info_bus.word};
                    st_next = c_wr ? rrad_pkg::ST_STEP : rrad_pkg::ST_RDOUT;
                end else if (i_mem_ack) begin
                    data_next = c_wr ? data_reg : i_mem_rdata;
                    st_next = c_wr ? rrad_pkg::ST_STEP : rrad_pkg::ST_RDOUT;
                end
            end
            rrad_pkg::ST_RDOUT: begin
                if (i_tx_ready) begin
                    data_next = {8'h00, data_reg[63:8]};
                    if (elem_end) begin
                        bidx_next = 3'h0;
                        st_next = rrad_pkg::ST_STEP;
                    end else begin
                        bidx_next = bidx_reg + 3'h1;
                    end
                end
            end
            rrad_pkg::ST_STEP: begin
                if (c_inc) begin
                    if (c_info) begin
                        iptr_next[c_sp] = iptr_reg[c_sp] + {12'h000, nb};
                    end else begin
                        ptr_next[c_sp] = ptr_reg[c_sp] + {12'h000, nb};
                    end
                end
                // A write whose data ran past the packet end stops here.
                if (cnt_reg == rrad_pkg::CNT_ONE || (c_wr && eop_reg)) begin
                    st_next = rrad_pkg::ST_CMD_LO;
                end else begin
                    cnt_next = cnt_reg - rrad_pkg::CNT_ONE;
                    st_next = c_wr ? rrad_pkg::ST_WDATA : rrad_pkg::ST_ACCESS;
                end
            end
            default: st_next = rrad_pkg::ST_CMD_LO;
        endcase
    end

    // -------------------------------------------------------------------
    // State registers
    // -------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_reg <= rrad_pkg::ST_CMD_LO;
            cmd_reg <= 16'h0000;
            cnt_reg <= rrad_pkg::CNT_ZERO;
            bidx_reg <= 3'h0;
            data_reg <= 64'h0;
            for (int i = 0; i < 8; i++) begin
                ptr_reg[i] <= rrad_pkg::PTR_RST;
                iptr_reg[i] <= rrad_pkg::PTR_RST;
            end
            err_reg <= 1'b0;
            eop_reg <= 1'b0;
            ok_reg <= 1'b0;
            inpkt_reg <= 1'b0;
            port_reg <= 16'h0000;
            end_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cmd_reg <= cmd_next;
            cnt_reg <= cnt_next;
            bidx_reg <= bidx_next;
            data_reg <= data_next;
            ptr_reg <= ptr_next;
            iptr_reg <= iptr_next;
            err_reg <= err_next;
            eop_reg <= eop_next;
            ok_reg <= ok_next;
            inpkt_reg <= inpkt_next;
            port_reg <= port_next;
            end_reg <= end_next;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic [2:0] sp_other;
    assign sp_other = c_sp + 3'h1;
    sequence seq_zero_cmd;
        st_reg == rrad_pkg::ST_CMD_HI && take && c_cnt == rrad_pkg::CNT_ZERO;
    endsequence
    sequence seq_addr_mem;
        st_reg == rrad_pkg::ST_ADR_HI && take && !c_info && c_cnt != rrad_pkg::CNT_ZERO;
    endsequence
    sequence seq_mem_read_done;
        o_mem_req && i_mem_ack && !o_mem_we;
    endsequence

    chk_addr_load: assert property (seq_addr_mem |=>
        ptr_reg[c_sp] == $past(new_addr))
        else $error("pointer not loaded from address word");
    chk_ptr_isolate: assert property (st_reg == rrad_pkg::ST_STEP |=>
        ptr_reg[$past(sp_other)] == $past(ptr_reg[sp_other]))
        else $error("another space pointer changed");
    chk_info_noreq: assert property (st_reg == rrad_pkg::ST_ACCESS && c_info |->
        !o_mem_req ##1 st_reg != rrad_pkg::ST_ACCESS)
        else $error("info access reached memory port");
    chk_inc_step: assert property (st_reg == rrad_pkg::ST_STEP && c_inc && !c_info |=>
        ptr_reg[c_sp] == $past(ptr_reg[c_sp]) + {12'h000, $past(nb)})
        else $error("pointer did not advance by element bytes");
    chk_zero_err: assert property (seq_zero_cmd |=>
        o_err_zero_count && st_reg != rrad_pkg::ST_ACCESS ##1 !o_mem_req)
        else $error("zero count not flagged or was executed");
    chk_err_sticky: assert property (o_err_zero_count && !i_err_clear |=>
        o_err_zero_count)
        else $error("error flag lost without clear");
    chk_rd_lsb: assert property (seq_mem_read_done |=>
        o_tx_valid && o_tx_data == $past(i_mem_rdata[7:0]))
        else $error("read data not sent low byte first");
    chk_wr_width: assert property ($rose(o_mem_req) && o_mem_we |->
        $past(st_reg) == rrad_pkg::ST_WDATA && $past(elem_end))
        else $error("write issued before whole element assembled");
endmodule

// ==== verilog/rrad_pkg.sv ====
/*
 Constants, field positions and state codes for the remote register access
 decoder. Assumes a single 50 MHz system clock and a byte-wide payload stream
 delivered by a UDP receive engine on that same clock.
*/
package rrad_pkg;

    // ------------------------------------------------------------------
    // Command word layout
    // ------------------------------------------------------------------
    localparam int CMD_WR = 15;
    localparam int CMD_ADR = 14;
    localparam int CMD_INFO = 13;
    localparam int CMD_SP_HI = 12;
    localparam int CMD_SP_LO = 10;
    localparam int CMD_SZ_HI = 9;
    localparam int CMD_SZ_LO = 8;
    localparam int CMD_INC = 7;
    localparam int CMD_CNT_HI = 6;
    localparam logic [6:0] CNT_ZERO = 7'h00;
    localparam logic [6:0] CNT_ONE = 7'h01;

    // ------------------------------------------------------------------
    // Link and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] UDP_PORT = 16'h6A2D;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [3:0] INFO_BYTES = 4'h2;
    localparam logic [3:0] ONE_BYTE = 4'h1;

    // ------------------------------------------------------------------
    // Info area word indices and descriptor fields
    // ------------------------------------------------------------------
    localparam logic [2:0] INFO_CHECK = 3'h0;
    localparam logic [2:0] INFO_SIZE = 3'h1;
    localparam logic [2:0] INFO_RANGE = 3'h2;
    localparam logic [2:0] INFO_PTR = 3'h3;
    localparam logic [7:0] CHECK_HI = 8'h5A;
    localparam logic [6:0] TYPE_REG = 7'h01;
    localparam logic [6:0] TYPE_MEM = 7'h02;
    localparam logic [6:0] TYPE_EEPROM = 7'h0E;
    localparam logic [6:0] TYPE_FLASH = 7'h0F;
    localparam int SZ_WR_BIT = 15;
    localparam int SZ_TYPE_HI = 14;
    localparam int SZ_TYPE_LO = 8;
    localparam int RG_P_LSB = 6;
    // Default descriptors: writable memory, 16-bit only, 64K byte range.
    localparam logic [15:0] SIZE_DFLT = 16'h8202;
    localparam logic [15:0] RANGE_DFLT = 16'h0010;

    // ------------------------------------------------------------------
    // Parser states
    // ------------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_CMD_LO = 8'h01,
        ST_CMD_HI = 8'h02,
        ST_ADR_LO = 8'h04,
        ST_ADR_HI = 8'h08,
        ST_WDATA = 8'h10,
        ST_ACCESS = 8'h20,
        ST_RDOUT = 8'h40,
        ST_STEP = 8'h80
    } rrad_state_t;

endpackage

// ==== verilog/rrad_info_if.sv ====
/*
 Carrier between the parser and the info area server. Assumes both ends
 sit on the same clock; the server answers combinationally.
*/
`timescale 1ns/10ps
interface rrad_info_if;
    logic [2:0] space;
    logic [15:0] addr;
    logic [15:0] ptr;
    logic [15:0] word;
    modport req (output space, output addr, output ptr, input word);
    modport srv (input space, input addr, input ptr, output word);
endinterface

// ==== verilog/rrad_info.sv ====
/*
 Read-only info area server for the eight memory spaces. Assumes the
 parser presents space, byte address and the space pointer; answers in the
 same cycle.
*/
`timescale 1ns/10ps
module rrad_info #(
    parameter logic [127:0] SIZE_DESC = {8{rrad_pkg::SIZE_DFLT}},
    parameter logic [127:0] RANGE_DESC = {8{rrad_pkg::RANGE_DFLT}},
    parameter logic [511:0] LABELS = 512'h0
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    rrad_info_if.srv bus
);
    logic [15:0] size_w;
    logic [15:0] range_w;
    logic is_flash;

    // -------------------------------------------------------------------
    // Word selection
    // -------------------------------------------------------------------
    // Offsets past the last label word read zero rather than aliasing.
    always_comb begin
        size_w = SIZE_DESC[{bus.space, 4'h0} +: 16];
        range_w = RANGE_DESC[{bus.space, 4'h0} +: 16];
        is_flash = size_w[rrad_pkg::SZ_TYPE_HI:rrad_pkg::SZ_TYPE_LO] == rrad_pkg::TYPE_FLASH;
        if (bus.addr[15:4] != 12'h000) begin
            bus.word = 16'h0000;
        end else begin
            case (bus.addr[3:1])
                rrad_pkg::INFO_CHECK: bus.word = {rrad_pkg::CHECK_HI, 5'h00, bus.space};
                rrad_pkg::INFO_SIZE: bus.word = size_w;
                rrad_pkg::INFO_RANGE: begin
                    // Erase and page exponents are forced off for non-flash.
                    bus.word = is_flash ? range_w
                        : {10'h000, range_w[rrad_pkg::RG_P_LSB-1:0]};
                end
                rrad_pkg::INFO_PTR: bus.word = bus.ptr;
                default: bus.word = LABELS[{bus.space, bus.addr[2:1], 4'h0} +: 16];
            endcase
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    chk_check_word: assert property (bus.addr == 16'h0000 |->
        bus.word[15:8] == rrad_pkg::CHECK_HI && bus.word[3:0] == {1'b0, bus.space})
        else $error("info check word wrong");
    chk_nonflash_range: assert property (bus.addr == 16'h0004 && !is_flash |->
        bus.word[15:rrad_pkg::RG_P_LSB] == 10'h000)
        else $error("non-flash range has erase or page exponent");
endmodule

// ==== tb/rrad_mem_model.sv ====
/* Byte-wide model of the eight memory spaces that answers with a delayed ack.
 Assumes one request at a time, held steady until its ack. */
`timescale 1ns/10ps
module rrad_mem_model (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [2:0] i_space,
    input wire logic [1:0] i_size,
    input wire logic [15:0] i_addr,
    input wire logic [63:0] i_wdata,
    input wire logic [3:0] i_delay,
    output logic o_ack = 1'b0,
    output logic [63:0] o_rdata = 64'h0
);
    logic [7:0] mem [0:2047];
    logic [3:0] n = 4'h0;
    logic [10:0] a;
    // Idle read data toggles every cycle, so a decoder that samples it late fails.
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_req && !o_ack) begin
            n <= n + 4'h1;
            if (n >= i_delay) begin
                n <= 4'h0;
                o_ack <= 1'b1;
                for (int b = 0; b < 8; b++) begin
                    a = {i_space, i_addr[7:0] + 8'(b)};
                    o_rdata[8*b +: 8] <= mem[a];
                    if (i_we && b < (1 << i_size)) mem[a] <= i_wdata[8*b +: 8];
                end
            end
        end
    end
endmodule

// ==== tb/tb.sv ====
/* Self-checking bench: sends command packets and checks the reply bytes.
 Assumes the memory model stands on the decoder's memory port. */
`timescale 1ns/10ps
module tb;
    localparam logic [127:0] SZ = {{4{16'h8202}}, 16'h8F04, 16'h8202, 16'h0E02, 16'h8202};
    localparam logic [127:0] RG = {{4{16'h0010}}, 16'h8414, 16'h0010, 16'hFFFF, 16'h0010};
    logic clk = 1'b0, rst = 1'b1, rx_v = 1'b0, rx_l = 1'b0, tx_rdy = 1'b1;
    logic clr = 1'b0, stall = 1'b0;
    logic [7:0] rx_d = 8'h00;
    logic [3:0] dly = 4'h0;
    logic [15:0] dport = 16'h6A2D, sport = 16'h1234, rport, madr;
    logic tx_v, rend, req, we, ack, err, rdy;
    logic [7:0] tx_d;
    logic [2:0] spc;
    logic [1:0] msz;
    logic [63:0] wd, rd;
    int fails = 0, tests_run = 0, ends = 0;
    logic [7:0] got[$];

    rrad_decoder #(.SIZE_DESC(SZ), .RANGE_DESC(RG)) i_dut (.i_clk(clk), .i_sys_rst(rst),
        .i_rx_valid(rx_v), .i_rx_data(rx_d), .i_rx_last(rx_l), .i_rx_dst_port(dport),
        .i_rx_src_port(sport), .o_rx_ready(rdy), .o_tx_valid(tx_v), .o_tx_data(tx_d),
        .i_tx_ready(tx_rdy), .o_reply_end(rend), .o_reply_port(rport), .o_mem_req(req),
        .o_mem_we(we), .o_mem_space(spc), .o_mem_size(msz), .o_mem_addr(madr),
        .o_mem_wdata(wd), .i_mem_ack(ack), .i_mem_rdata(rd), .o_err_zero_count(err),
        .i_err_clear(clr));
    rrad_mem_model i_mem (.i_clk(clk), .i_req(req), .i_we(we), .i_space(spc), .i_size(msz),
        .i_addr(madr), .i_wdata(wd), .i_delay(dly), .o_ack(ack), .o_rdata(rd));

    // Clock at 50 MHz.
    initial forever #10 clk = ~clk;

    // Reply sink; stalling every other cycle exercises the held reply byte.
    always @(posedge clk) begin
        tx_rdy <= stall ? ~tx_rdy : 1'b1;
        if (tx_v && tx_rdy) got.push_back(tx_d);
        if (rend) ends <= ends + 1;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (fails == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Bytes are held until the edge at which ready is seen high.
    task automatic pkt(input logic [7:0] s[$]);
        got.delete();
        foreach (s[i]) begin
            rx_v <= 1'b1;
            rx_d <= s[i];
            rx_l <= (i == s.size() - 1);
            @(posedge clk);
            while (rdy !== 1'b1) @(posedge clk);
        end
        rx_v <= 1'b0;
        rx_l <= 1'b0;
    endtask

    task automatic run(input logic [7:0] s[$], input logic [7:0] e[$]);
        int e0;
        e0 = ends;
        pkt(s);
        for (int i = 0; i < 500 && ends == e0; i++) @(posedge clk);
        chk(64'(ends - e0), 64'h1);
        chk(64'(got.size()), 64'(e.size()));
        foreach (e[i]) chk(got[i], e[i]);
    endtask

    // Main sequence of packets.
    initial begin
        logic [15:0] c, s, g;
        int e1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(err, 1'b0);
        dly <= 4'h3;
        stall <= 1'b1;
        run('{8'h82, 8'hC2, 8'h10, 8'h00, 8'h44, 8'h33, 8'h22, 8'h11, 8'h88, 8'h77, 8'h66,
            8'h55, 8'h01, 8'h40, 8'h13, 8'h00, 8'h01, 8'h43, 8'h10, 8'h00, 8'h84, 8'h41,
            8'h10, 8'h00}, '{8'h11, 8'h44, 8'h33, 8'h22, 8'h11, 8'h88, 8'h77, 8'h66, 8'h55,
            8'h44, 8'h33, 8'h22, 8'h11, 8'h88, 8'h77, 8'h66, 8'h55});
        chk(rport, sport);
        dly <= 4'h0;
        stall <= 1'b0;
        run('{8'h01, 8'hCC, 8'h40, 8'h00, 8'hAA, 8'h01, 8'h4C, 8'h40, 8'h00, 8'h01, 8'h0C,
            8'h01, 8'h61, 8'h06, 8'h00, 8'h01, 8'h6D, 8'h06, 8'h00},
            '{8'hAA, 8'hAA, 8'h18, 8'h00, 8'h40, 8'h00});
        for (int k = 0; k < 8; k++) begin
            c = 16'h6183 | (16'(k) << 10);
            s = SZ[16*k +: 16];
            g = RG[16*k +: 16];
            if (s[14:8] != 7'h0F) g = g & 16'h003F;
            run('{c[7:0], c[15:8], 8'h00, 8'h00}, '{8'(k), 8'h5A, s[7:0], s[15:8], g[7:0],
                g[15:8]});
        end
        run('{8'h80, 8'h41, 8'h20, 8'h00, 8'h01, 8'h61, 8'h06, 8'h00}, '{8'h18, 8'h00});
        chk(err, 1'b1);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (2) @(posedge clk);
        chk(err, 1'b0);
        dport <= 16'h1235;
        e1 = ends;
        pkt('{8'h01, 8'h61, 8'h00, 8'h00});
        repeat (60) @(posedge clk);
        chk(64'(got.size()), 64'h0);
        chk(64'(ends - e1), 64'h0);
        results();
    end

    // Watchdog cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        results();
    end
endmodule
